// file: counter_consts.svh
// constants for the presettable 4-bit counter
`ifndef COUNTER_CONSTS_SVH
`define COUNTER_CONSTS_SVH
`define CNT_WIDTH      4
`define CNT_ZERO       4'h0
`define CNT_STEP       4'h1
`define CNT_TERMINAL   4'hf
`endif

// file: counter_pkg.sv
// types for the presettable 4-bit counter
`include "counter_consts.svh"
package counter_pkg;
    typedef logic [`CNT_WIDTH-1:0] count_t;
    typedef enum logic [3:0] {
        MODE_CLEAR   = 4'h1,
        MODE_LOAD    = 4'h2,
        MODE_COUNT   = 4'h4,
        MODE_INHIBIT = 4'h8
    } mode_e;
endpackage

// file: counter_ctl_if.sv
// control bundle between mode decoder and counter core
`timescale 1ns/1ns
interface counter_ctl_if;
    counter_pkg::mode_e mode;
    modport decoder (output mode);
    modport core    (input  mode);
endinterface

// file: counter_mode_decode.sv
// decodes clear, load and enables into one mode
`timescale 1ns/1ns
module counter_mode_decode (
    input  wire logic   sync_zero_n,
    input  wire logic   load_n,
    input  wire logic   parallel_count_enable,
    input  wire logic   trickle_count_enable,
    counter_ctl_if.decoder ctl
);
    // clear beats load beats count
    always_comb begin
        if (!sync_zero_n) begin
            ctl.mode = counter_pkg::MODE_CLEAR;
        end else if (!load_n) begin
            ctl.mode = counter_pkg::MODE_LOAD;
        end else if (parallel_count_enable && trickle_count_enable) begin
            ctl.mode = counter_pkg::MODE_COUNT;
        end else begin
            ctl.mode = counter_pkg::MODE_INHIBIT;
        end
    end
endmodule // counter_mode_decode

// file: sync_presettable_4bit_counter.sv
// 4-bit synchronous presettable binary up-counter
`timescale 1ns/1ns
`include "counter_consts.svh"
module sync_presettable_4bit_counter (
    input  wire logic                   clk,
    input  wire logic                   srst,
    input  wire logic                   sync_zero_n,
    input  wire logic                   load_n,
    input  wire logic                   parallel_count_enable,
    input  wire logic                   trickle_count_enable,
    input  wire counter_pkg::count_t    preset,
    output counter_pkg::count_t         count,
    output logic                        carry_out
);
    counter_pkg::count_t count_q;
    counter_pkg::count_t count_d;
    counter_pkg::count_t shadow_q;
    counter_pkg::count_t run_base_q;
    counter_pkg::count_t run_len_q;
    wire [`CNT_WIDTH:0]  look_ahead;
    counter_ctl_if       ctl ();

    counter_mode_decode u_decode (
        .sync_zero_n           (sync_zero_n),
        .load_n                (load_n),
        .parallel_count_enable (parallel_count_enable),
        .trickle_count_enable  (trickle_count_enable),
        .ctl                   (ctl.decoder)
    );

    // per-bit look-ahead: a bit toggles when every lower bit is one
    assign look_ahead[0] = 1'h1;
    for (genvar i = 0; i < `CNT_WIDTH; i++) begin : g_look_ahead
        assign look_ahead[i + 1] = look_ahead[i] & count_q[i];
    end

    // next count from decoded mode
    always_comb begin
        unique case (ctl.mode)
            counter_pkg::MODE_CLEAR:   count_d = `CNT_ZERO;
            counter_pkg::MODE_LOAD:    count_d = preset;
            counter_pkg::MODE_COUNT:   count_d = count_q ^ look_ahead[`CNT_WIDTH-1:0];
            counter_pkg::MODE_INHIBIT: count_d = count_q;
            default:                   count_d = count_q;
        endcase
    end

    // all bits update together on the rising edge only
    always_ff @(posedge clk) begin
        if (srst) begin
            count_q <= `CNT_ZERO;
        end else begin
            count_q <= count_d;
        end
    end

    // count output straight from the state flip-flops
    assign count = count_q;

    // carry is the top look-ahead gated by trickle enable; parallel enable plays no part
    assign carry_out = trickle_count_enable && look_ahead[`CNT_WIDTH];

    // shadow count from the raw pins, apart from decoder and look-ahead
    always_ff @(posedge clk) begin
        if (srst) begin
            shadow_q <= `CNT_ZERO;
        end else if (!sync_zero_n) begin
            shadow_q <= `CNT_ZERO;
        end else if (!load_n) begin
            shadow_q <= preset;
        end else if (parallel_count_enable && trickle_count_enable) begin
            shadow_q <= shadow_q + `CNT_STEP;
        end
    end

    // length of the current run of counting edges, wraps with the count
    always_ff @(posedge clk) begin
        if (srst) begin
            run_len_q <= `CNT_ZERO;
        end else if (sync_zero_n && load_n && parallel_count_enable && trickle_count_enable) begin
            run_len_q <= run_len_q + `CNT_STEP;
        end else begin
            run_len_q <= `CNT_ZERO;
        end
    end

    // count value at the first counting edge of a run
    always_ff @(posedge clk) begin
        if (srst) begin
            run_base_q <= `CNT_ZERO;
        end else if (run_len_q == `CNT_ZERO) begin
            run_base_q <= count_q;
        end
    end

    // controls as sampled at one rising edge, in priority order
    sequence seq_clear_req;
        !sync_zero_n;
    endsequence
    sequence seq_load_req;
        sync_zero_n && !load_n;
    endsequence
    sequence seq_count_req;
        sync_zero_n && load_n && parallel_count_enable && trickle_count_enable;
    endsequence
    sequence seq_hold_req;
        sync_zero_n && load_n && !(parallel_count_enable && trickle_count_enable);
    endsequence

    // a load followed by three counting edges
    sequence seq_load_then_count;
        seq_load_req ##1 seq_count_req [*3];
    endsequence

    // clear wins over load and both enables
    AST_CLEAR_ZERO: assert property (@(posedge clk) disable iff (srst)
        seq_clear_req |=> count == `CNT_ZERO)
        else $error("clear did not zero count");

    // clear with load low still zeroes
    AST_CLEAR_OVER_LOAD: assert property (@(posedge clk) disable iff (srst)
        !sync_zero_n && !load_n |=> count == `CNT_ZERO)
        else $error("load beat clear");

    // load takes the preset whatever the enables
    AST_LOAD_PRESET: assert property (@(posedge clk) disable iff (srst)
        seq_load_req |=> count == $past(preset))
        else $error("load did not take preset");

    // load with trickle enable low still takes the preset
    AST_LOAD_IGNORES_ENABLES: assert property (@(posedge clk) disable iff (srst)
        sync_zero_n && !load_n && !trickle_count_enable |=> count == $past(preset))
        else $error("load blocked by low enable");

    // preset bit zero lands in count bit zero, bit three in bit three
    AST_LOAD_LSB: assert property (@(posedge clk) disable iff (srst)
        seq_load_req |=> count[0] == $past(preset[0]) && count[3] == $past(preset[3]))
        else $error("preset bits landed out of order");

    // both enables high step the count by one
    AST_COUNT_INC: assert property (@(posedge clk) disable iff (srst)
        seq_count_req |=> count == $past(count) + `CNT_STEP)
        else $error("count did not increment");

    // two counting edges in a row step the count by two
    AST_TWO_COUNTS: assert property (@(posedge clk) disable iff (srst)
        seq_count_req ##1 seq_count_req |=> count == $past(count, 2) + `CNT_STEP + `CNT_STEP)
        else $error("two counting edges did not add two");

    // either enable low keeps the count
    AST_INHIBIT_HOLD: assert property (@(posedge clk) disable iff (srst)
        seq_hold_req |=> $stable(count))
        else $error("inhibited count changed");

    // parallel enable low at the edge blocks counting, whatever it did between edges
    AST_HOLD_ONE_ENABLE: assert property (@(posedge clk) disable iff (srst)
        sync_zero_n && load_n && !parallel_count_enable |=> $stable(count))
        else $error("count moved with parallel enable low");

    // one counting step from fifteen wraps to zero
    AST_WRAP: assert property (@(posedge clk) disable iff (srst)
        sync_zero_n && load_n && parallel_count_enable && trickle_count_enable
        && count == `CNT_TERMINAL |=> count == `CNT_ZERO)
        else $error("count did not wrap to zero");

    // preset then three counts lands three above the preset
    AST_RUN_FROM_LOAD: assert property (@(posedge clk) disable iff (srst)
        seq_load_then_count |=> count == $past(preset, 4) + `CNT_STEP + `CNT_STEP + `CNT_STEP)
        else $error("count after load and three counts is wrong");

    // a run of counting edges adds its length to the value it started from
    AST_RUN_LENGTH: assert property (@(posedge clk) disable iff (srst)
        run_len_q != `CNT_ZERO |-> count == run_base_q + run_len_q)
        else $error("count does not match length of counting run");

    // the count moves only after an edge that asked it to
    AST_CHANGE_AT_EDGE: assert property (@(posedge clk) disable iff (srst)
        !$stable(count) |-> $past(srst)
        || !$past(sync_zero_n && load_n && !(parallel_count_enable && trickle_count_enable)))
        else $error("count changed without a sampled request");

    // pin-level shadow agrees with the count after every edge
    AST_SHADOW_MATCH: assert property (@(posedge clk) disable iff (srst)
        count == shadow_q)
        else $error("count differs from pin-level shadow");

    // reset clears the count at the next edge
    AST_RESET_ZERO: assert property (@(posedge clk)
        srst |=> count == `CNT_ZERO)
        else $error("reset did not zero count");

    // trickle enable high at terminal count raises carry
    AST_CARRY_HIGH: assert property (@(posedge clk) disable iff (srst)
        trickle_count_enable && count == `CNT_TERMINAL |-> carry_out)
        else $error("carry missing at terminal count");

    // carry is low whenever trickle enable is low
    AST_CARRY_GATED: assert property (@(posedge clk) disable iff (srst)
        !trickle_count_enable |-> !carry_out)
        else $error("carry high with trickle enable low");

    // parallel enable low does not hold carry down
    AST_CARRY_NO_PAR: assert property (@(posedge clk) disable iff (srst)
        trickle_count_enable && !parallel_count_enable && count == `CNT_TERMINAL |-> carry_out)
        else $error("carry held low by parallel enable");

    // carry never shows off terminal count
    AST_CARRY_ONLY_TERM: assert property (@(posedge clk) disable iff (srst)
        carry_out |-> count == `CNT_TERMINAL)
        else $error("carry high off terminal count");
endmodule // sync_presettable_4bit_counter

// file: count_far_side.sv
// far-side logic: count-length decode and upper cascaded stage
`timescale 1ns/1ns
module count_far_side (
    input  wire logic                clk,
    input  wire logic                srst,
    input  wire counter_pkg::count_t count,
    input  wire logic                carry_out,
    output logic                     zero_n,
    output counter_pkg::count_t      upper_q
);
    // clear low once the decoded maximum of nine is reached
    assign zero_n = (count != 4'h9);
    // next stage counts whenever the lower carry enables it
    always_ff @(posedge clk) begin
        if (srst) begin
            upper_q <= 4'h0;
        end else if (carry_out) begin
            upper_q <= upper_q + 4'h1;
        end
    end
endmodule // count_far_side

// file: testbench.sv
// self-checking bench for the presettable counter
`timescale 1ns/1ns
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin miscompares++; \
    $display("mismatch %s exp %h got %h", n, e, s); end end
module testbench;
    logic                clk = 1'b0, srst = 1'b1, zn = 1'b1, ld = 1'b1, pe = 1'b0;
    logic                te = 1'b0, use_dec = 1'b0, carry_out, dec_zn;
    counter_pkg::count_t pre = 4'h0, count, upper;
    int                  miscompares = 0, check_count = 0;
    // free-running clock
    always #5 clk = ~clk;
    sync_presettable_4bit_counter dut (.clk(clk), .srst(srst), .sync_zero_n(use_dec ? dec_zn : zn),
        .load_n(ld), .parallel_count_enable(pe), .trickle_count_enable(te), .preset(pre),
        .count(count), .carry_out(carry_out));
    count_far_side far (.clk(clk), .srst(srst), .count(count), .carry_out(carry_out),
        .zero_n(dec_zn), .upper_q(upper));
    // drive at a falling edge, check after the rising edge that follows
    task automatic go(input logic z, l, p, t, input counter_pkg::count_t d, e);
        {zn, ld, pe, te, pre} = {z, l, p, t, d};
        @(negedge clk);
        `CHK("count", e, count)
        `CHK("carry_out", t && e == 4'hf, carry_out)
    endtask
    task automatic print_verdict;
        if (miscompares == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // hang guard
    initial begin
        #20000 miscompares++;
        print_verdict;
    end
    // main sequence
    initial begin
        repeat (4) @(negedge clk);
        srst = 1'b0;
        `CHK("count", 4'h0, count)
        go(1'b0, 1'b0, 1'b1, 1'b1, 4'h5, 4'h0);
        go(1'b1, 1'b0, 1'b0, 1'b0, 4'h1, 4'h1);
        go(1'b1, 1'b0, 1'b0, 1'b0, 4'hc, 4'hc);
        for (int i = 1; i <= 6; i++) begin
            go(1'b1, 1'b1, 1'b1, 1'b1, 4'h0, 4'(4'hc + i));
        end
        `CHK("upper", 4'h1, upper)
        go(1'b1, 1'b1, 1'b0, 1'b1, 4'h0, 4'h2);
        // enable glitch in the low phase, then in the high phase
        #2 pe = 1'b1;
        #1 pe = 1'b0;
        @(posedge clk);
        #2 pe = 1'b1;
        #1 pe = 1'b0;
        @(negedge clk);
        go(1'b1, 1'b1, 1'b0, 1'b1, 4'h0, 4'h2);
        go(1'b1, 1'b1, 1'b1, 1'b0, 4'h0, 4'h2);
        go(1'b1, 1'b0, 1'b1, 1'b0, 4'hf, 4'hf);
        go(1'b1, 1'b1, 1'b0, 1'b1, 4'h0, 4'hf);
        // mid-run reset for one edge, then reload fifteen
        srst = 1'b1;
        @(negedge clk);
        srst = 1'b0;
        `CHK("count", 4'h0, count)
        `CHK("carry_out", 1'b0, carry_out)
        go(1'b1, 1'b0, 1'b0, 1'b0, 4'hf, 4'hf);
        use_dec = 1'b1;
        for (int i = 0; i <= 10; i++) begin
            go(1'b1, 1'b1, 1'b1, 1'b1, 4'h0, 4'(i % 10));
        end
        print_verdict;
    end
endmodule // testbench
